/* File: iep_master_model.sv */
// bus master model driving the serial clock and data lines
`timescale 1ns/1ps
module iep_master (
	input wire logic ref_clk,
	input wire logic sda_w,
	output logic scl,
	output logic sda_pull
);
	initial begin
		scl = 1'b1;
		sda_pull = 1'b0;
	end
	task automatic q();
		repeat (2) @(posedge ref_clk);
	endtask
	// data moves only while clock low
	task automatic bit_io(input logic b, output logic s);
		sda_pull <= ~b;
		q();
		scl <= 1'b1;
		q();
		q();
		s = sda_w;
		scl <= 1'b0;
		q();
	endtask
	task automatic start();
		sda_pull <= 1'b0;
		q();
		scl <= 1'b1;
		q();
		sda_pull <= 1'b1;
		q();
		scl <= 1'b0;
		q();
	endtask
	// stop: data rises with clock high
	task automatic stop();
		sda_pull <= 1'b1;
		q();
		scl <= 1'b1;
		q();
		sda_pull <= 1'b0;
		q();
	endtask
	// msb first, line released in ack slot
	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], s);
		end
		bit_io(1'b1, s);
		ack = ~s;
	endtask
	// master acks all but the last byte
	task automatic rbyte(input logic mack, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, s);
			d[i] = s;
		end
		bit_io(~mack, s);
	endtask
	task automatic rawbits(input int n);
		logic s;
		for (int i = 0; i < n; i++) begin
			bit_io(i[0], s);
		end
	endtask
endmodule

/* File: iep_pkg.sv */
// constants and types of the two-wire memory slave
package iep_pkg;
	localparam int ARRAY_DEPTH = 128;
	localparam int PAGE_BYTES = 8;
	localparam logic [3:0] DEV_TYPE = 4'hA; // arbitrary value
	localparam logic [3:0] BIT_LAST = 4'h7;
	localparam logic [3:0] BIT_FULL = 4'h8;
	localparam logic [7:0] ERASED = 8'hFF;
	localparam logic [6:0] PTR_RST = 7'h00;
	localparam int WR_TIME_MS = 10;
	localparam int REF_CLK_HZ = 10000000;
	localparam int WR_CYCLES_DFLT = WR_TIME_MS * (REF_CLK_HZ / 1000);
	localparam int TMR_W = 17;

	typedef enum logic [2:0] {
		L_IDLE = 3'b000,
		L_RX = 3'b001,
		L_ACK = 3'b010,
		L_TX = 3'b011,
		L_MACK = 3'b100
	} iep_lstate_t;

	typedef enum logic [1:0] {
		PH_DEV = 2'b00,
		PH_WADDR = 2'b01,
		PH_DATA = 2'b10
	} iep_phase_t;

	typedef enum logic [1:0] {
		C_IDLE = 2'b00,
		C_ERASE = 2'b01,
		C_PROG = 2'b10,
		C_WAIT = 2'b11
	} iep_cstate_t;

	typedef struct packed {
		logic [3:0] row;
		logic [PAGE_BYTES-1:0] valid;
		logic [PAGE_BYTES-1:0][7:0] data;
	} iep_page_t;
endpackage

/* File: iep_slave.sv */
// two-wire memory slave with page write and timed array commit
`timescale 1ns/1ps
module iep_slave #(
	parameter int WR_CYCLES = iep_pkg::WR_CYCLES_DFLT
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic link_clk,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe,
	input wire logic addr_strap_bit0,
	input wire logic addr_strap_bit1,
	input wire logic addr_strap_bit2,
	output logic write_busy
);
	import iep_pkg::*;

	// link side reset and pin synchronisers
	logic lrst_s1, lrst;
	logic [4:0] pin_s1, pin_s2;
	logic scl_d, sda_d;
	logic req_tgl_r, req_tgl_nxt;
	logic done_tgl_r, done_tgl_nxt;
	logic done_s1, done_s2, done_s3;
	logic req_s1, req_s2, req_s3;

	always_ff @(posedge link_clk or posedge rst) begin
		if (rst) begin
			lrst_s1 <= 1'b1;
			lrst <= 1'b1;
		end else begin
			lrst_s1 <= 1'b0;
			lrst <= lrst_s1;
		end
	end

	always_ff @(posedge link_clk or posedge lrst) begin
		if (lrst) begin
			pin_s1 <= 5'h03;
			pin_s2 <= 5'h03;
			scl_d <= 1'b1;
			sda_d <= 1'b1;
			done_s1 <= 1'b0;
			done_s2 <= 1'b0;
			done_s3 <= 1'b0;
		end else begin
			pin_s1 <= {addr_strap_bit2, addr_strap_bit1, addr_strap_bit0,
				scl_i, sda_i};
			pin_s2 <= pin_s1;
			scl_d <= pin_s2[1];
			sda_d <= pin_s2[0];
			done_s1 <= done_tgl_r;
			done_s2 <= done_s1;
			done_s3 <= done_s2;
		end
	end

	logic scl_q, sda_q, scl_rise, scl_fall, start_ev, stop_ev, done_ev;
	logic [2:0] strap;
	assign scl_q = pin_s2[1];
	assign sda_q = pin_s2[0];
	assign strap = pin_s2[4:2];
	assign scl_rise = scl_q & ~scl_d;
	assign scl_fall = ~scl_q & scl_d;
	assign start_ev = scl_q & scl_d & sda_d & ~sda_q;
	assign stop_ev = scl_q & scl_d & ~sda_d & sda_q;
	assign done_ev = done_s2 ^ done_s3;

	// link state
	iep_lstate_t state_r, state_nxt;
	iep_phase_t phase_r, phase_nxt;
	logic [3:0] bitcnt_r, bitcnt_nxt;
	logic [7:0] sr_r, sr_nxt;
	logic [6:0] ptr_r, ptr_nxt;
	logic [2:0] col_r, col_nxt;
	logic rw_r, rw_nxt, mack_r, mack_nxt, busy_l_r, busy_l_nxt;
	logic oe_r, oe_nxt;
	iep_page_t page_r, page_nxt;
	logic [7:0] array_r [ARRAY_DEPTH];
	logic [7:0] array_nxt [ARRAY_DEPTH];
	logic [7:0] rd_byte;
	logic addr_hit;

	// array changes only while the link is busy and refuses its address, so direct read is safe
	assign rd_byte = array_r[ptr_r];
	assign addr_hit = sr_r[7:4] == DEV_TYPE && sr_r[3:1] == strap;

	always_comb begin
		state_nxt = state_r;
		phase_nxt = phase_r;
		bitcnt_nxt = bitcnt_r;
		sr_nxt = sr_r;
		ptr_nxt = ptr_r;
		col_nxt = col_r;
		rw_nxt = rw_r;
		mack_nxt = mack_r;
		busy_l_nxt = busy_l_r;
		oe_nxt = oe_r;
		page_nxt = page_r;
		req_tgl_nxt = req_tgl_r;
		if (done_ev) begin
			busy_l_nxt = 1'b0;
			page_nxt.valid = '0;
		end
		if (start_ev) begin
			state_nxt = L_RX;
			phase_nxt = PH_DEV;
			bitcnt_nxt = 4'h0;
			oe_nxt = 1'b0;
		end else if (stop_ev) begin
			state_nxt = L_IDLE;
			oe_nxt = 1'b0;
			if (|page_r.valid && !busy_l_r) begin
				req_tgl_nxt = ~req_tgl_r;
				busy_l_nxt = 1'b1;
			end
		end else begin
			unique case (state_r)
				L_IDLE: begin
				end
				L_RX: begin
					if (scl_rise && bitcnt_r != BIT_FULL) begin
						sr_nxt = {sr_r[6:0], sda_q};
						bitcnt_nxt = bitcnt_r + 4'h1;
					end else if (scl_fall && bitcnt_r == BIT_FULL) begin
						if (phase_r != PH_DEV || (addr_hit && !busy_l_r)) begin
							state_nxt = L_ACK;
							oe_nxt = 1'b1;
						end else begin
							state_nxt = L_IDLE;
						end
						if (phase_r == PH_DEV) begin
							rw_nxt = sr_r[0];
						end
					end
				end
				L_ACK: begin
					if (scl_fall) begin
						oe_nxt = 1'b0;
						bitcnt_nxt = 4'h0;
						state_nxt = L_RX;
						unique case (phase_r)
							PH_DEV: begin
								if (rw_r) begin
									state_nxt = L_TX;
									sr_nxt = rd_byte;
									oe_nxt = ~rd_byte[7];
								end else begin
									phase_nxt = PH_WADDR;
									page_nxt.valid = '0;
								end
							end
							PH_WADDR: begin
								phase_nxt = PH_DATA;
								ptr_nxt = sr_r[6:0];
								page_nxt.row = sr_r[6:3];
								col_nxt = sr_r[2:0];
							end
							default: begin
								page_nxt.data[col_r] = sr_r;
								page_nxt.valid[col_r] = 1'b1;
								col_nxt = col_r + 3'h1;
								ptr_nxt = ptr_r + 7'h01;
							end
						endcase
					end
				end
				L_TX: begin
					if (scl_fall) begin
						bitcnt_nxt = bitcnt_r + 4'h1;
						if (bitcnt_r == BIT_LAST) begin
							oe_nxt = 1'b0;
							state_nxt = L_MACK;
							ptr_nxt = ptr_r + 7'h01;
						end else begin
							sr_nxt = {sr_r[6:0], 1'b0};
							oe_nxt = ~sr_r[6];
						end
					end
				end
				L_MACK: begin
					if (scl_rise) begin
						mack_nxt = ~sda_q;
					end else if (scl_fall) begin
						if (mack_r) begin
							state_nxt = L_TX;
							bitcnt_nxt = 4'h0;
							sr_nxt = rd_byte;
							oe_nxt = ~rd_byte[7];
						end else begin
							state_nxt = L_IDLE;
						end
					end
				end
				default: begin
					state_nxt = L_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge link_clk or posedge lrst) begin
		if (lrst) begin
			state_r <= L_IDLE;
			phase_r <= PH_DEV;
			bitcnt_r <= 4'h0;
			sr_r <= 8'h00;
			ptr_r <= PTR_RST;
			col_r <= 3'h0;
			rw_r <= 1'b0;
			mack_r <= 1'b0;
			busy_l_r <= 1'b0;
			oe_r <= 1'b0;
			page_r <= '0;
			req_tgl_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			phase_r <= phase_nxt;
			bitcnt_r <= bitcnt_nxt;
			sr_r <= sr_nxt;
			ptr_r <= ptr_nxt;
			col_r <= col_nxt;
			rw_r <= rw_nxt;
			mack_r <= mack_nxt;
			busy_l_r <= busy_l_nxt;
			oe_r <= oe_nxt;
			page_r <= page_nxt;
			req_tgl_r <= req_tgl_nxt;
		end
	end
	assign sda_oe = oe_r;
	assign sda_o = 1'b0 & oe_r;

	// core side: commit engine and array
	iep_cstate_t cst_r, cst_nxt;
	logic [TMR_W-1:0] tmr_r, tmr_nxt;
	logic busy_r, busy_nxt;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			req_s1 <= 1'b0;
			req_s2 <= 1'b0;
			req_s3 <= 1'b0;
		end else begin
			req_s1 <= req_tgl_r;
			req_s2 <= req_s1;
			req_s3 <= req_s2;
		end
	end

	always_comb begin
		cst_nxt = cst_r;
		tmr_nxt = tmr_r;
		done_tgl_nxt = done_tgl_r;
		array_nxt = array_r;
		unique case (cst_r)
			C_IDLE: begin
				if (req_s2 ^ req_s3) begin
					cst_nxt = C_ERASE;
				end
			end
			C_ERASE: begin
				for (int i = 0; i < PAGE_BYTES; i++) begin
					if (page_r.valid[i]) begin
						array_nxt[{page_r.row, 3'(i)}] = ERASED;
					end
				end
				cst_nxt = C_PROG;
			end
			C_PROG: begin
				for (int i = 0; i < PAGE_BYTES; i++) begin
					if (page_r.valid[i]) begin
						array_nxt[{page_r.row, 3'(i)}] = page_r.data[i];
					end
				end
				tmr_nxt = '0;
				cst_nxt = C_WAIT;
			end
			C_WAIT: begin
				tmr_nxt = tmr_r + TMR_W'(1);
				if (tmr_r == TMR_W'(WR_CYCLES - 1)) begin
					cst_nxt = C_IDLE;
					done_tgl_nxt = ~done_tgl_r;
				end
			end
		endcase
		busy_nxt = cst_nxt != C_IDLE;
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			cst_r <= C_IDLE;
			tmr_r <= '0;
			done_tgl_r <= 1'b0;
			busy_r <= 1'b0;
			for (int i = 0; i < ARRAY_DEPTH; i++) begin
				array_r[i] <= ERASED;
			end
		end else begin
			cst_r <= cst_nxt;
			tmr_r <= tmr_nxt;
			done_tgl_r <= done_tgl_nxt;
			busy_r <= busy_nxt;
			array_r <= array_nxt;
		end
	end
	assign write_busy = busy_r;

	// checks
	sequence s_erase_then_prog;
		cst_r == C_ERASE ##1 cst_r == C_PROG ##1 cst_r == C_WAIT;
	endsequence
	sequence s_addr_byte_done;
		state_r == L_RX && phase_r == PH_DEV && bitcnt_r == BIT_FULL
			&& scl_fall && !start_ev && !stop_ev;
	endsequence

	property p_ack_low;
		@(posedge link_clk) disable iff (lrst)
		(state_r == L_ACK && scl_q && !stop_ev) |-> oe_r;
	endproperty
	a_ack_low: assert property (p_ack_low) else $error("ack not low");

	property p_start;
		@(posedge link_clk) disable iff (lrst)
		start_ev |=> state_r == L_RX && phase_r == PH_DEV
			&& bitcnt_r == 4'h0 && !oe_r;
	endproperty
	a_start: assert property (p_start) else $error("start missed");

	property p_commit_on_stop;
		@(posedge link_clk) disable iff (lrst)
		(req_tgl_r != $past(req_tgl_r)) |-> $past(stop_ev)
			&& $past(|page_r.valid);
	endproperty
	a_commit_on_stop: assert property (p_commit_on_stop)
		else $error("commit without stop");

	property p_busy_nak;
		@(posedge link_clk) disable iff (lrst)
		(s_addr_byte_done and busy_l_r) |=> state_r == L_IDLE && !oe_r;
	endproperty
	a_busy_nak: assert property (p_busy_nak)
		else $error("acked while busy");

	property p_addr_match;
		@(posedge link_clk) disable iff (lrst)
		(s_addr_byte_done and addr_hit && !busy_l_r) |=> state_r == L_ACK
			&& oe_r;
	endproperty
	a_addr_match: assert property (p_addr_match)
		else $error("own address not acked");

	property p_read_incr;
		@(posedge link_clk) disable iff (lrst)
		(state_r == L_TX && scl_fall && bitcnt_r == BIT_LAST && !start_ev
			&& !stop_ev) |=> ptr_r == 7'($past(ptr_r) + 7'h01);
	endproperty
	a_read_incr: assert property (p_read_incr)
		else $error("pointer not advanced");

	property p_nack_release;
		@(posedge link_clk) disable iff (lrst)
		(state_r == L_MACK && scl_fall && !mack_r && !start_ev && !stop_ev)
			|=> state_r == L_IDLE && !oe_r;
	endproperty
	a_nack_release: assert property (p_nack_release)
		else $error("line held after nack");

	property p_stable_high;
		@(posedge link_clk) disable iff (lrst)
		(scl_q && $past(scl_q) && !$past(start_ev) && !$past(stop_ev))
			|-> $stable(oe_r);
	endproperty
	a_stable_high: assert property (p_stable_high)
		else $error("data moved while clock high");

	property p_erase_first;
		@(posedge ref_clk) disable iff (rst)
		(cst_r == C_IDLE && (req_s2 ^ req_s3)) |=> s_erase_then_prog;
	endproperty
	a_erase_first: assert property (p_erase_first)
		else $error("program without erase");

	property p_wait_bound;
		@(posedge ref_clk) disable iff (rst)
		cst_r == C_WAIT |-> tmr_r < TMR_W'(WR_CYCLES) && busy_r;
	endproperty
	a_wait_bound: assert property (p_wait_bound)
		else $error("write time overrun");
endmodule

/* File: iep_slave_bench.sv */
// self-checking bench for the two-wire memory slave
`timescale 1ns/1ps
module iep_slave_bench;
	import iep_pkg::*;
	localparam int WR = 400;
	logic ref_clk = 1'b0;
	logic link_clk = 1'b0;
	logic rst = 1'b1;
	logic [2:0] strap = 3'h5;
	logic scl, sda_pull, sda_o, sda_oe, write_busy;
	wire sda_w = ~(sda_pull | (sda_oe & ~sda_o));
	int num_errors = 0;
	int cmp_count = 0;
	logic [7:0] exp_q[$];
	logic ack;
	logic [7:0] d;
	iep_slave #(.WR_CYCLES(WR)) iep_slave_i (.ref_clk(ref_clk), .rst(rst),
		.link_clk(link_clk), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o),
		.sda_oe(sda_oe), .addr_strap_bit0(strap[0]),
		.addr_strap_bit1(strap[1]), .addr_strap_bit2(strap[2]),
		.write_busy(write_busy));
	iep_master iep_master_i (.ref_clk(ref_clk), .sda_w(sda_w), .scl(scl),
		.sda_pull(sda_pull));
	initial begin
		forever #50 ref_clk = ~ref_clk;
	end
	initial begin
		#3.3;
		forever #7.5 link_clk = ~link_clk;
	end
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic ack_chk(input logic e);
		chk({7'h0, ack}, {7'h0, e});
	endtask
	function automatic logic [7:0] dev(input logic rw);
		return {DEV_TYPE, strap, rw};
	endfunction
	task automatic wait_commit(input int lo);
		int n;
		n = 0;
		while (write_busy !== 1'b1 && n < 50) begin
			@(negedge ref_clk);
			n++;
		end
		chk({7'h0, write_busy}, 8'h01); // commit starts after stop
		if (n >= 50) give_verdict();
		n = 0;
		while (write_busy !== 1'b0 && n < WR + 100) begin
			@(negedge ref_clk);
			n++;
		end
		chk({7'h0, write_busy}, 8'h00); // commit ends in time
		chk({7'h0, n >= lo}, 8'h01); // busy for the whole time
		if (n >= WR + 100) give_verdict();
		repeat (10) @(posedge ref_clk);
	endtask
	task automatic wr(input logic [6:0] a, input int n, input logic [7:0] b,
		input int part);
		iep_master_i.start();
		iep_master_i.wbyte(dev(1'b0), ack);
		ack_chk(1'b1); // address acknowledged
		iep_master_i.wbyte({1'b0, a}, ack);
		ack_chk(1'b1); // word address acknowledged
		for (int i = 0; i < n; i++) begin
			iep_master_i.wbyte(b + 8'(i), ack);
			ack_chk(1'b1); // data acknowledged
		end
		iep_master_i.rawbits(part);
		chk({7'h0, write_busy}, 8'h00); // no commit before stop
		iep_master_i.stop();
	endtask
	task automatic rd(input logic [6:0] a, input logic set);
		int n;
		n = exp_q.size();
		if (set) begin
			iep_master_i.start();
			iep_master_i.wbyte(dev(1'b0), ack);
			ack_chk(1'b1); // address acknowledged
			iep_master_i.wbyte({1'b0, a}, ack);
			ack_chk(1'b1); // word address acknowledged
		end
		iep_master_i.start();
		iep_master_i.wbyte(dev(1'b1), ack);
		ack_chk(1'b1); // read direction accepted
		for (int i = 0; i < n; i++) begin
			iep_master_i.rbyte(i < n - 1, d);
			chk(d, exp_q[i]); // successive bytes
		end
		chk({7'h0, sda_oe}, 8'h00); // line released after nack
		iep_master_i.stop();
		exp_q.delete();
	endtask
	task automatic t_single();
		wr(7'h20, 1, 8'h5A, 0);
		wait_commit(WR); // full write time
		wr(7'h20, 1, 8'hA5, 0);
		wait_commit(WR); // rewrite needs no erase command
		exp_q = '{8'hA5, 8'hFF};
		rd(7'h20, 1'b1); // stored byte, erased neighbour
		$display("test single done");
	endtask
	task automatic t_straps();
		for (int j = 0; j < 2; j++) begin
			strap <= j[0] ? 3'h2 : 3'h5;
			repeat (5) @(posedge ref_clk);
			for (int s = 0; s < 8; s++) begin
				iep_master_i.start();
				iep_master_i.wbyte({DEV_TYPE, 3'(s), 1'b0}, ack);
				ack_chk(3'(s) == strap); // only own straps answer
				iep_master_i.stop();
			end
		end
		iep_master_i.start();
		iep_master_i.wbyte({~DEV_TYPE, strap, 1'b0}, ack);
		ack_chk(1'b0); // other device type ignored
		iep_master_i.stop();
		$display("test straps done");
	endtask
	task automatic t_busy();
		wr(7'h48, 1, 8'h66, 0);
		iep_master_i.start();
		iep_master_i.wbyte(dev(1'b0), ack);
		ack_chk(1'b0); // own address ignored while busy
		iep_master_i.stop();
		wait_commit(0);
		$display("test busy done");
	endtask
	task automatic t_page();
		wr(7'h16, 10, 8'h30, 0); // ten bytes wrap in one row
		wait_commit(WR);
		exp_q = '{8'hA5};
		rd(7'h00, 1'b0); // pointer now at 0x20, two rows past the written row
		exp_q = '{8'h32, 8'h33, 8'h34, 8'h35, 8'h36, 8'h37, 8'h38,
			8'h39, 8'hFF, 8'hFF};
		rd(7'h10, 1'b1); // wrapped page, read across rows
		wr(7'h58, 8, 8'h70, 0); // eight bytes from column zero
		wait_commit(WR);
		exp_q = '{8'hFF};
		rd(7'h00, 1'b0); // pointer moved to next row
		exp_q = '{8'h70, 8'h71, 8'h72, 8'h73, 8'h74, 8'h75, 8'h76,
			8'h77};
		rd(7'h58, 1'b1); // whole row in order
		$display("test page done");
	endtask
	task automatic t_partial();
		wr(7'h40, 1, 8'h11, 4); // stop inside a byte
		wait_commit(0);
		exp_q = '{8'h11, 8'hFF};
		rd(7'h40, 1'b1); // only the complete byte kept
		$display("test partial done");
	endtask
	initial begin
		rst = 1'b1;
		repeat (2) @(posedge ref_clk);
		rst <= 1'b0;
		repeat (10) @(posedge ref_clk);
		t_single();
		t_straps();
		t_busy();
		t_page();
		t_partial();
		give_verdict();
	end
endmodule
